//--- inc/ppc_pkg.sv
// Package for the port P / port J pin control block
package ppc_pkg;

  // Register indices (printed offsets are not all multiples of four)
  localparam logic [7:0] PPC_IDX_P_DRIVE  = 8'h1B;
  localparam logic [7:0] PPC_IDX_P_PULL   = 8'h1C;
  localparam logic [7:0] PPC_IDX_P_POL    = 8'h1D;
  localparam logic [7:0] PPC_IDX_P_IRQEN  = 8'h1E;
  localparam logic [7:0] PPC_IDX_P_FLAGS  = 8'h1F;
  localparam logic [7:0] PPC_IDX_J_DATA   = 8'h28;
  localparam logic [7:0] PPC_IDX_J_LEVEL  = 8'h29;
  localparam logic [7:0] PPC_IDX_J_DIR    = 8'h2A;

  // Bus geometry
  localparam int         PPC_ADDR_W       = 8;
  localparam int         PPC_P_W          = 8;
  localparam int         PPC_J_W          = 2;
  localparam int         PPC_J_LSB        = 6;

  // Reset values
  localparam logic [7:0] PPC_RST_P_DRIVE  = 8'h00;
  localparam logic [7:0] PPC_RST_P_PULL   = 8'h00;
  localparam logic [7:0] PPC_RST_P_POL    = 8'h00;
  localparam logic [7:0] PPC_RST_P_IRQEN  = 8'h00;
  localparam logic [7:0] PPC_RST_P_FLAGS  = 8'h00;
  localparam logic [1:0] PPC_RST_J_DATA   = 2'h0;
  localparam logic [1:0] PPC_RST_J_DIR    = 2'h0;

  // AXI responses
  localparam logic [1:0] PPC_RESP_OKAY    = 2'h0;
  localparam logic [1:0] PPC_RESP_SLVERR  = 2'h2;

endpackage : ppc_pkg

//--- hdl/ppc_top.sv
// Port P / port J pin control with edge interrupts, AXI4-Lite slave
// Summary of operation
// RULE1: Drive bit one reduces output strength.
// RULE2: Pull enable acts only on inputs.
// RULE3: Pull enables clear after reset.
// RULE4: Polarity zero: falling edge, pull-up.
// RULE5: Polarity one: rising edge, pull-down.
// RULE6: Per-pin enable masks interrupt request.
// RULE7: Selected edge sets pin flag.
// RULE8: Write one clears flag; zero keeps.
// RULE9: Request when any enabled flag set.
// RULE10: Data read: latch if output, else pin.
// RULE11: Level register reads pins; writes ignored.
// RULE12: Direction bits only for pins 7,6.
// RULE13: Reads may lag direction by two cycles.
// RULE14: Synchronise pins; flags set while masked.
// RULE15: Registers always accessible; unused bits zero.
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser for a group of asynchronous pin levels
module ppc_sync2 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Level in, synchronised level out
  input  wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0]      sync_out
);
  import ppc_pkg::*;

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Only the second stage is read; the first may be metastable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : ppc_sync2

module ppc_top (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write address
  input  wire logic [ppc_pkg::PPC_ADDR_W+1:0] s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ppc_pkg::PPC_ADDR_W+1:0] s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Port P pins
  input  wire logic [ppc_pkg::PPC_P_W-1:0] port_p_in,
  input  wire logic [ppc_pkg::PPC_P_W-1:0] port_p_dir,
  output logic [ppc_pkg::PPC_P_W-1:0]      port_p_reduced_drive,
  output logic [ppc_pkg::PPC_P_W-1:0]      port_p_pullup_en,
  output logic [ppc_pkg::PPC_P_W-1:0]      port_p_pulldown_en,
  output logic                             port_p_irq,
  // Port J pins 7:6
  input  wire logic [ppc_pkg::PPC_J_W-1:0] port_j_in,
  output logic [ppc_pkg::PPC_J_W-1:0]      port_j_out,
  output logic [ppc_pkg::PPC_J_W-1:0]      port_j_oe_n
);
  import ppc_pkg::*;

  logic [7:0]         drive_q;
  logic [7:0]         pull_q;
  logic [7:0]         pol_q;
  logic [7:0]         irqen_q;
  logic [7:0]         flags_q;
  logic [1:0]         jdata_q;
  logic [1:0]         jdir_q;
  logic [7:0]         p_sync;
  logic [7:0]         p_prev_q;
  logic [2:0]         prime_q;
  logic [1:0]         j_sync;
  logic [7:0]         edge_raw;
  logic [7:0]         edge_hit;
  logic               aw_held_q;
  logic               w_held_q;
  logic [7:0]         aw_idx_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic               wr_go;
  logic [7:0]         wr_byte;
  logic               wr_lane0;
  logic [7:0]         rd_idx;
  logic [7:0]         rd_byte;
  logic               rd_hit;
  logic               wr_hit;
  logic [7:0]         clr_mask;
  logic               wr_drive;
  logic               wr_pull;
  logic               wr_pol;
  logic               wr_irqen;
  logic               wr_flags;
  logic               wr_jdata;
  logic               wr_jdir;

  // Port P pin levels cross into the bus clock
  ppc_sync2 #(
    .WIDTH    (PPC_P_W)
  ) u_sync_p (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (port_p_in),                   // RULE14
    .sync_out (p_sync)
  );

  // Port J pin levels cross into the bus clock
  ppc_sync2 #(
    .WIDTH    (PPC_J_W)
  ) u_sync_j (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (port_j_in),                   // RULE13
    .sync_out (j_sync)
  );

  // Previous synchronised level for the edge compare
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p_prev_q <= 8'h00;
    end else begin
      p_prev_q <= p_sync;
    end
  end

  // Edge compare held off until the pipeline holds real samples,
  // so a pin that idles high gives no false edge after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prime_q <= 3'h0;
    end else begin
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  // Edge selection per pin
  always_comb begin
    for (int i = 0; i < PPC_P_W; i++) begin
      edge_raw[i] = pol_q[i] ? (p_sync[i] & ~p_prev_q[i])    // RULE5
                             : (~p_sync[i] & p_prev_q[i]);   // RULE4
    end
  end

  assign edge_hit = prime_q[2] ? edge_raw : 8'h00;           // RULE7

  // Write channel capture, address and data in either order
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign wr_go         = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_idx_q  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_idx_q  <= s_axi_awaddr[PPC_ADDR_W+1:2];
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  assign wr_byte  = wdata_q[7:0];
  assign wr_lane0 = wr_go && wstrb_q[0];

  // Decode of the write index
  always_comb begin
    unique case (aw_idx_q)
      PPC_IDX_P_DRIVE, PPC_IDX_P_PULL, PPC_IDX_P_POL, PPC_IDX_P_IRQEN,
      PPC_IDX_P_FLAGS, PPC_IDX_J_DATA, PPC_IDX_J_LEVEL,
      PPC_IDX_J_DIR: wr_hit = 1'b1;
      default:       wr_hit = 1'b0;
    endcase
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PPC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? PPC_RESP_OKAY : PPC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Per-register write strobes, lane 0 carries the byte
  assign wr_drive = wr_lane0 && (aw_idx_q == PPC_IDX_P_DRIVE);
  assign wr_pull  = wr_lane0 && (aw_idx_q == PPC_IDX_P_PULL);
  assign wr_pol   = wr_lane0 && (aw_idx_q == PPC_IDX_P_POL);
  assign wr_irqen = wr_lane0 && (aw_idx_q == PPC_IDX_P_IRQEN);
  assign wr_flags = wr_lane0 && (aw_idx_q == PPC_IDX_P_FLAGS);
  assign wr_jdata = wr_lane0 && (aw_idx_q == PPC_IDX_J_DATA);
  assign wr_jdir  = wr_lane0 && (aw_idx_q == PPC_IDX_J_DIR);

  // Port P drive strength
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_q <= PPC_RST_P_DRIVE;
    end else if (wr_drive) begin
      drive_q <= wr_byte;                    // RULE15
    end
  end

  // Port P pull enables, all off out of reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pull_q <= PPC_RST_P_PULL;              // RULE3
    end else if (wr_pull) begin
      pull_q <= wr_byte;
    end
  end

  // Port P polarity, picks edge and pull kind
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pol_q <= PPC_RST_P_POL;
    end else if (wr_pol) begin
      pol_q <= wr_byte;
    end
  end

  // Port P interrupt enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irqen_q <= PPC_RST_P_IRQEN;
    end else if (wr_irqen) begin
      irqen_q <= wr_byte;
    end
  end

  // Clear mask from a one written to the flag register
  assign clr_mask = wr_flags ? wr_byte : 8'h00;  // RULE8

  // Sticky edge flags, a new edge beats a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= PPC_RST_P_FLAGS;
    end else begin
      flags_q <= (flags_q & ~clr_mask) | edge_hit;  // RULE7 RULE14
    end
  end

  // Port J output latch, bits 7:6 of the byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      jdata_q <= PPC_RST_J_DATA;
    end else if (wr_jdata) begin
      jdata_q <= wr_byte[PPC_J_LSB +: PPC_J_W];  // RULE10
    end
  end

  // Port J direction, bits 7:6 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      jdir_q <= PPC_RST_J_DIR;
    end else if (wr_jdir) begin
      jdir_q <= wr_byte[PPC_J_LSB +: PPC_J_W];   // RULE12
    end
  end

  // Pin-side outputs
  assign port_p_reduced_drive = drive_q & port_p_dir;          // RULE1
  assign port_p_pullup_en     = pull_q & ~port_p_dir & ~pol_q; // RULE2 RULE4
  assign port_p_pulldown_en   = pull_q & ~port_p_dir & pol_q;  // RULE5
  assign port_p_irq           = |(flags_q & irqen_q);          // RULE6 RULE9
  assign port_j_out           = jdata_q;
  assign port_j_oe_n          = ~jdir_q;                       // RULE12

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx        = s_axi_araddr[PPC_ADDR_W+1:2];

  // Read data mux, unused J bits zero
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    unique case (rd_idx)
      PPC_IDX_P_DRIVE: rd_byte = drive_q;
      PPC_IDX_P_PULL:  rd_byte = pull_q;
      PPC_IDX_P_POL:   rd_byte = pol_q;
      PPC_IDX_P_IRQEN: rd_byte = irqen_q;
      PPC_IDX_P_FLAGS: rd_byte = flags_q;
      PPC_IDX_J_DATA:  rd_byte = {(jdir_q & jdata_q) | (~jdir_q & j_sync),
                                  6'h00};    // RULE10 RULE15
      PPC_IDX_J_LEVEL: rd_byte = {j_sync, 6'h00};    // RULE11
      PPC_IDX_J_DIR:   rd_byte = {jdir_q, 6'h00};
      default:         rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= PPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_hit ? PPC_RESP_OKAY : PPC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : ppc_top

`default_nettype wire

//--- sim/ppc_props.sv
// Port-level checker for the pin control block
`timescale 1ns/10ps
`default_nettype none
module ppc_props (
  // Clock, reset and bus
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pins
  input wire logic [7:0]  port_p_dir,
  input wire logic [7:0]  port_p_reduced_drive,
  input wire logic [7:0]  port_p_pullup_en,
  input wire logic [7:0]  port_p_pulldown_en,
  input wire logic        port_p_irq,
  input wire logic [1:0]  port_j_oe_n
);
  // One clock domain for every property
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_drive_out_only: assert property (
    (port_p_reduced_drive & ~port_p_dir) == 8'h00)
    else $error("reduced drive on input pin");
  a_pull_in_only: assert property (
    ((port_p_pullup_en | port_p_pulldown_en) & port_p_dir) == 8'h00)
    else $error("pull device on output pin");
  a_pull_one_kind: assert property (
    (port_p_pullup_en & port_p_pulldown_en) == 8'h00)
    else $error("pull-up and pull-down together");
  a_pull_reset_off: assert property ($rose(aresetn) |->
    (port_p_pullup_en | port_p_pulldown_en) == 8'h00)
    else $error("pull device on after reset");
  a_dir_reset_in: assert property ($rose(aresetn) |->
    port_j_oe_n == 2'h3) else $error("port J driven after reset");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_read_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_write_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  // Main scenarios reached
  c_irq: cover property ($rose(port_p_irq));
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : ppc_props
bind ppc_top ppc_props u_props (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .port_p_dir, .port_p_reduced_drive,
  .port_p_pullup_en, .port_p_pulldown_en, .port_p_irq, .port_j_oe_n);
`default_nettype wire

//--- sim/ppc_pins.sv
// Model of the external pins on ports P and J
`timescale 1ns/10ps
`default_nettype none
module ppc_pins (
  // Outside world levels
  input wire logic [7:0] p_drv,
  input wire logic [1:0] j_drv,
  // Block side
  input wire logic [1:0] port_j_out,
  input wire logic [1:0] port_j_oe_n,
  output logic [7:0]     port_p_in,
  output logic [1:0]     port_j_in
);
  // Port P pins follow the outside level
  assign port_p_in = p_drv;
  // J pin shows the block's value where it drives
  assign port_j_in = (~port_j_oe_n & port_j_out) | (port_j_oe_n & j_drv);
endmodule : ppc_pins
`default_nettype wire

//--- sim/ppc_top_test.sv
// Testbench for the pin control block
`timescale 1ns/10ps
`default_nettype none
module ppc_top_test;
  import ppc_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, port_p_irq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, port_j_out, port_j_oe_n, port_j_in;
  logic [1:0] j_drv = 2'h2;
  logic [7:0] p_drv = 0, port_p_dir = 0, port_p_in, port_p_reduced_drive;
  logic [7:0] port_p_pullup_en, port_p_pulldown_en;
  int errors = 0, n_compared = 0;
  // Clock
  always #5 aclk = ~aclk;
  ppc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .port_p_in, .port_p_dir, .port_p_reduced_drive,
    .port_p_pullup_en, .port_p_pulldown_en, .port_p_irq, .port_j_in,
    .port_j_out, .port_j_oe_n);
  ppc_pins u_pins (.p_drv, .j_drv, .port_j_out, .port_j_oe_n,
    .port_p_in, .port_j_in);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, input logic [7:0] d,
                    input logic [1:0] er = PPC_RESP_OKAY);
    logic a, w, b;
    logic [1:0] r;
    b = 0;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!b) begin
      @(negedge aclk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (a) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    chk({29'h0, b, r}, {29'h0, 1'b1, er});
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] d,
                    input logic [1:0] er = PPC_RESP_OKAY);
    logic a, b;
    logic [31:0] v;
    logic [1:0] r;
    b = 0;
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!b) begin
      @(negedge aclk);
      a = s_axi_arvalid && s_axi_arready;
      b = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (a) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    chk({b, 29'h0, r}, {1'b1, 29'h0, er});
    if (er === PPC_RESP_OKAY) chk(v, {24'h000000, d});
  endtask : rd
  task automatic t_reset;
    logic [7:0] idx [6] = '{PPC_IDX_P_DRIVE, PPC_IDX_P_PULL, PPC_IDX_P_POL,
      PPC_IDX_P_IRQEN, PPC_IDX_P_FLAGS, PPC_IDX_J_DIR};
    foreach (idx[k]) rd(idx[k], 8'h00);
    rd(8'h20, 8'h00, PPC_RESP_SLVERR);
    @(negedge aclk);
    chk(port_p_pullup_en | port_p_pulldown_en, 0);
    chk(port_j_oe_n, 2'h3);
  endtask : t_reset
  task automatic t_pads;
    @(posedge aclk);
    port_p_dir <= 8'h33;
    wr(PPC_IDX_P_DRIVE, 8'hFF);
    wr(PPC_IDX_P_PULL, 8'hFF);
    wr(PPC_IDX_P_POL, 8'h0F);
    rd(PPC_IDX_P_POL, 8'h0F);
    @(negedge aclk);
    chk(port_p_reduced_drive, 8'h33);
    chk(port_p_pullup_en, 8'hC0);
    chk(port_p_pulldown_en, 8'h0C);
  endtask : t_pads
  task automatic t_irq;
    wr(PPC_IDX_P_IRQEN, 8'h01);
    p_drv <= 8'hA5;
    repeat (3) @(posedge aclk);
    rd(PPC_IDX_P_FLAGS, 8'h05);
    p_drv <= 8'h00;
    repeat (3) @(posedge aclk);
    rd(PPC_IDX_P_FLAGS, 8'hA5);
    @(negedge aclk);
    chk(port_p_irq, 1);
    wr(PPC_IDX_P_FLAGS, 8'h01);
    rd(PPC_IDX_P_FLAGS, 8'hA4);
    @(negedge aclk);
    chk(port_p_irq, 0);
    wr(PPC_IDX_P_IRQEN, 8'h04);
    @(negedge aclk);
    chk(port_p_irq, 1);
  endtask : t_irq
  task automatic t_portj;
    rd(PPC_IDX_J_DATA, 8'h80);
    rd(PPC_IDX_J_LEVEL, 8'h80);
    wr(PPC_IDX_J_DATA, 8'h40);
    wr(PPC_IDX_J_DIR, 8'hFF);
    rd(PPC_IDX_J_DIR, 8'hC0);
    chk(port_j_oe_n, 2'h0);
    chk(port_j_out, 2'h1);
    rd(PPC_IDX_J_DATA, 8'h40);
    wr(PPC_IDX_J_LEVEL, 8'hFF);
    rd(PPC_IDX_J_LEVEL, 8'h40);
  endtask : t_portj
  task automatic t_midreset;
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(PPC_IDX_P_PULL, 8'h00);
    rd(PPC_IDX_P_FLAGS, 8'h00);
    @(negedge aclk);
    chk(port_p_pullup_en | port_p_pulldown_en, 0);
    chk(port_j_oe_n, 2'h3);
  endtask : t_midreset
  task automatic print_verdict;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_pads;
    t_irq;
    t_portj;
    t_midreset;
    print_verdict;
  end
  // Watchdog
  initial begin
    #100000;
    errors++;
    print_verdict;
  end
endmodule : ppc_top_test
`default_nettype wire
